// [verilog/swc_top.sv]
`timescale 1ns/100ps
`default_nettype none
// Function
// (R1) wake on reset pin, watchdog, interrupts
// (R2) reset pin resets; others continue execution
// (R3) powerdown flag set at power-up, cleared on sleep
// (R4) watchdog time-out clears timeout flag
// (R5) timer wakes only as asynchronous counter
// (R6) capture, special event, start/stop wake sources
// (R7) serial slave transfers also wake
// (R8) clocked peripherals cannot wake from sleep
// (R9) prefetch instruction after power-down instruction
// (R10) wake needs individual enable, global enable ignored
// (R11) global enable clear: resume in line
// (R12) global enable set: next instruction, then vector
// (R13) software puts nop after power-down
// (R14) pending interrupt makes power-down a nop
// (R15) late interrupt: finish sleep, wake at once
// (R16) software clears watchdog before power-down
// (R17) 1024 tosc start-up in crystal mode only
// (R18) sleep clears watchdog, flags, stops oscillator; code clears pd_q but sets to_q
// (R19) time-out in sleep wakes, else resets
// (R20) two dummy cycles before vector
module swc_top
  import swc_pkg::*;
(
  // ahb-lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins
  input  wire logic        ext_reset_pin_n,
  // peripheral interrupt flag levels
  input  wire logic [8:0]  irq_flags,
  // core side
  output logic             osc_enable,
  output logic             core_halt,
  output logic             prefetch_next,
  output logic             vector_req,
  output logic [15:0]      vector_addr,
  output logic             device_reset
);
  import swc_pkg::*;

  swc_state_e  state_q;
  logic [7:0]  ctrl_q;
  logic [15:0] irq_q;
  logic        pd_q;
  logic        to_q;
  logic [15:0] wdt_q;
  logic [10:0] ost_q;
  logic [1:0]  dummy_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        rst_lvl;
  logic        rst_seen_q;
  logic [8:0]  wake_ok;
  logic        wake_any;
  logic        cmd_sleep;
  logic        cmd_wdclr;
  logic        cmd_resume;
  logic        wdt_tmo;
  logic        ahb_go;

  // reset pin through the synchroniser; level high means asserted
  swc_sync u_sync
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (~ext_reset_pin_n),
    .level   (rst_lvl)
  );

  // address phase accepted
  assign ahb_go = hsel & hready & htrans[1];

  // command strobes decoded in the write data phase
  assign cmd_sleep  = wr_pend_q & (wr_addr_q == SWC_CMD_OFS) & hwdata[SWC_CMD_SLEEP];
  assign cmd_wdclr  = wr_pend_q & (wr_addr_q == SWC_CMD_OFS) & hwdata[SWC_CMD_WDCLR];
  assign cmd_resume = wr_pend_q & (wr_addr_q == SWC_CMD_OFS) & hwdata[SWC_CMD_RESUME];

  // qualify each wake source; clocked peripherals never wake from sleep
  always_comb
  begin
    wake_ok = irq_flags & irq_q[8:0];                                     // [R10]
    wake_ok[SWC_SRC_TIMER]  = wake_ok[SWC_SRC_TIMER] & ctrl_q[SWC_CTRL_ASYNC]; // [R5]
    wake_ok[SWC_SRC_SPECEV] = wake_ok[SWC_SRC_SPECEV] & ctrl_q[SWC_CTRL_ASYNC]
                              & ctrl_q[SWC_CTRL_EXTCK] & ctrl_q[SWC_CTRL_CMPMD]; // [R6]
    wake_ok[SWC_SRC_CLKED]  = (state_q != SWC_SLEEP) & wake_ok[SWC_SRC_CLKED]; // [R8]
  end
  // ext int, port change, capture, start/stop, slave and usart transfers [R1] [R6] [R7]
  assign wake_any = |wake_ok;

  // watchdog expiry
  assign wdt_tmo = ctrl_q[SWC_CTRL_WDTEN] & (wdt_q == SWC_WDT_CYCLES);

  // write capture for the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= ahb_go & hwrite;
      wr_addr_q <= haddr;
    end
  end

  // configuration and enable registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= 8'h00;
      irq_q  <= 16'h0000;
    end
    else if (rst_lvl)
    begin
      irq_q <= 16'h0000; // global enable and enables clear on the reset pin, not on a watchdog device reset [R2]
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == SWC_CTRL_OFS)
        ctrl_q <= hwdata[7:0];
      if (wr_addr_q == SWC_IRQ_OFS)
        irq_q <= hwdata[15:0];
    end
  end

  // read data, zero for unmapped offsets; slave never waits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ahb_go & ~hwrite)
    begin
      unique case (haddr)
        SWC_CTRL_OFS:   hrdata <= {24'h00_0000, ctrl_q};
        SWC_IRQ_OFS:    hrdata <= {16'h0000, irq_q};
        SWC_STAT_OFS:   hrdata <= {25'h000_0000, state_q, 2'b00, to_q, pd_q};
        SWC_WDTCNT_OFS: hrdata <= {16'h0000, wdt_q};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // okay response, zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // power sequencing state machine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= SWC_RUN;
      ost_q   <= 11'h000;
      dummy_q <= 2'h0;
    end
    else if (rst_lvl)
      state_q <= SWC_RUN; // reset pin: back to run, out of sleep; ctrl and the pd/to flags are kept [R1] [R2]
    else
    begin
      unique case (state_q)
        SWC_RUN:
          // pending enabled interrupt turns the power-down into a nop [R14]
          if (cmd_sleep & ~wake_any)
            state_q <= SWC_SLEEP;
        SWC_SLEEP:
          if (wake_any | wdt_tmo)
          begin
            // crystal modes wait for the oscillator, rc does not [R17]
            ost_q   <= SWC_OST_CYCLES;
            state_q <= ctrl_q[SWC_CTRL_XTAL] ? SWC_OST : SWC_NEXT; // [R19]
          end
        SWC_OST:
          if (ost_q == 11'h001)
            state_q <= SWC_NEXT;
          else
            ost_q <= ost_q - 11'h001;
        SWC_NEXT:
          // the prefetched instruction runs first in both cases [R11] [R12]
          if (cmd_resume)
          begin
            dummy_q <= SWC_DUMMY_CYCLES;
            // global enable decides between vectoring and running in line
            state_q <= (irq_q[SWC_IRQ_GLOBAL] & wake_any) ? SWC_DUMMY : SWC_RUN;
          end
        SWC_DUMMY:
          if (dummy_q == 2'h1)
            state_q <= SWC_RUN; // two dummy cycles then vector [R20]
          else
            dummy_q <= dummy_q - 2'h1;
        default:
          state_q <= SWC_RUN;
      endcase
    end
  end

  // watchdog count; cleared by sleep, clear command and expiry in any state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wdt_q <= 16'h0000;
    else if (rst_lvl | ~ctrl_q[SWC_CTRL_WDTEN])
      wdt_q <= 16'h0000;
    else if ((cmd_sleep & ~wake_any & state_q == SWC_RUN) | cmd_wdclr | wdt_tmo)
      wdt_q <= 16'h0000; // sleep clears but leaves it running [R18]
    else
      wdt_q <= wdt_q + 16'h0001;
  end

  // status flags; a time-out clear wins over a set in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pd_q <= 1'b1; // power-up sets the powerdown flag [R3]
      to_q <= 1'b1;
    end
    else
    begin
      if (state_q == SWC_RUN & cmd_sleep & ~wake_any)
      begin
        pd_q <= 1'b0; // [R3] [R18] [R15]
        to_q <= 1'b1;
      end
      else if (state_q == SWC_RUN & cmd_wdclr)
      begin
        pd_q <= 1'b1;
        to_q <= 1'b1;
      end
      // last assignment wins, so a coinciding sleep still clears pd
      if (wdt_tmo)
        to_q <= 1'b0; // any time-out, in sleep too [R4]
    end
  end

  // core side outputs, all registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_enable    <= 1'b1;
      core_halt     <= 1'b0;
      prefetch_next <= 1'b0;
      vector_req    <= 1'b0;
      vector_addr   <= 16'h0000;
      device_reset  <= 1'b0;
    end
    else
    begin
      // oscillator driver off while asleep [R18]
      osc_enable    <= ~(state_q == SWC_SLEEP & ~(wake_any | wdt_tmo));
      core_halt     <= (state_q == SWC_SLEEP) | (state_q == SWC_OST);
      prefetch_next <= state_q == SWC_RUN & cmd_sleep & ~wake_any; // [R9]
      vector_req    <= state_q == SWC_DUMMY & dummy_q == 2'h1;      // [R12]
      vector_addr   <= SWC_VECTOR;
      // reset pin, or time-out in any state but sleep [R2] [R19]
      device_reset  <= rst_lvl | (wdt_tmo & state_q != SWC_SLEEP);
    end
  end

  // assertions
  property p_pd_sleep;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SWC_RUN & cmd_sleep & ~wake_any & ~wdt_tmo & ~rst_lvl) |=> !pd_q;
  endproperty
  a_pd_sleep: assert property (p_pd_sleep) else $error("pd not cleared"); // [R3]

  property p_to_clr;
    @(posedge hclk) disable iff (!hresetn) wdt_tmo |=> !to_q;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("to not cleared"); // [R4]

  property p_nop;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SWC_RUN & cmd_sleep & wake_any & ~wdt_tmo) |=> $stable(pd_q) && state_q == SWC_RUN;
  endproperty
  a_nop: assert property (p_nop) else $error("sleep not a nop"); // [R14]

  property p_rc;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SWC_SLEEP & wake_any & ~ctrl_q[SWC_CTRL_XTAL] & ~rst_lvl) |=> state_q == SWC_NEXT;
  endproperty
  a_rc: assert property (p_rc) else $error("rc wake delayed"); // [R17]

  property p_osc_off;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SWC_SLEEP & ~wake_any & ~wdt_tmo) |=> !osc_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc still on"); // [R18]

  sequence s_dummy;
    state_q == SWC_DUMMY ##1 state_q == SWC_DUMMY;
  endsequence
  // the vector request is registered, so it shows in the first run cycle
  property p_vec;
    @(posedge hclk) disable iff (!hresetn || rst_lvl)
    (state_q == SWC_NEXT && $past(state_q) != SWC_NEXT) ##0 1 ##[1:300]
    (state_q == SWC_DUMMY && $past(state_q) == SWC_NEXT)
    |-> s_dummy ##1 (state_q == SWC_RUN && vector_req);
  endproperty
  a_vec: assert property (p_vec) else $error("dummy cycles wrong"); // [R20]

  property p_wdt_reset;
    @(posedge hclk) disable iff (!hresetn)
    (wdt_tmo & state_q == SWC_RUN) |=> device_reset;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("no wdt reset"); // [R19]

  property p_clked;
    @(posedge hclk) disable iff (!hresetn)
    (state_q == SWC_SLEEP & irq_flags == 9'h100 & ~wdt_tmo & ~rst_lvl) |=> state_q == SWC_SLEEP;
  endproperty
  a_clked: assert property (p_clked) else $error("clocked irq woke"); // [R8]

endmodule // swc_top
`default_nettype wire

// [verilog/swc_pkg.sv]
package swc_pkg;

  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] SWC_CTRL_OFS   = 8'h00; // config: wdt enable, crystal mode
  localparam logic [7:0] SWC_IRQ_OFS    = 8'h04; // interrupt enables and global enable
  localparam logic [7:0] SWC_CMD_OFS    = 8'h08; // command strobes
  localparam logic [7:0] SWC_STAT_OFS   = 8'h0C; // flags and state (read only)
  localparam logic [7:0] SWC_WDTCNT_OFS = 8'h10; // watchdog count (read only)

  // ctrl fields
  localparam int SWC_CTRL_WDTEN = 0;
  localparam int SWC_CTRL_XTAL  = 1;
  localparam int SWC_CTRL_ASYNC = 2; // async_timer runs as asynchronous counter
  localparam int SWC_CTRL_EXTCK = 3; // async_timer uses external clock
  localparam int SWC_CTRL_CMPMD = 4; // capture_compare_unit in compare mode

  // irq enable / flag bit positions (same layout for enables and flags)
  localparam int SWC_SRC_EXTINT  = 0;
  localparam int SWC_SRC_PORTCHG = 1;
  localparam int SWC_SRC_TIMER   = 2; // async_timer overflow
  localparam int SWC_SRC_CAPT    = 3;
  localparam int SWC_SRC_SPECEV  = 4;
  localparam int SWC_SRC_SSPSS   = 5; // start/stop detect
  localparam int SWC_SRC_SSPXFR  = 6; // slave transmit/receive
  localparam int SWC_SRC_USART   = 7; // synchronous slave transfer
  localparam int SWC_SRC_CLKED   = 8; // needs on-chip clocks
  localparam int SWC_NSRC        = 9;
  localparam int SWC_IRQ_GLOBAL  = 15;

  // command bits
  localparam int SWC_CMD_SLEEP  = 0;
  localparam int SWC_CMD_WDCLR  = 1;
  localparam int SWC_CMD_RESUME = 2; // core finished the instruction after power-down

  // status fields
  localparam int SWC_STAT_PD    = 0;
  localparam int SWC_STAT_TO    = 1;
  localparam int SWC_STAT_STATE = 4;

  localparam logic [15:0] SWC_VECTOR = 16'h0004; // interrupt vector address

  // watchdog period in cycles and oscillator start-up
  localparam logic [15:0] SWC_WDT_CYCLES   = 16'h0100;
  localparam int          SWC_OST_TOSC     = 1024;
  localparam real         SWC_TOSC_NS      = 10.0;
  localparam real         SWC_CLK_NS       = 10.0;
  localparam logic [10:0] SWC_OST_CYCLES   =
    11'($rtoi((SWC_OST_TOSC * SWC_TOSC_NS + SWC_CLK_NS - 1.0) / SWC_CLK_NS));
  localparam logic [1:0]  SWC_DUMMY_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    SWC_RUN   = 3'b000,
    SWC_SLEEP = 3'b001,
    SWC_OST   = 3'b010,
    SWC_NEXT  = 3'b011,
    SWC_DUMMY = 3'b100
  } swc_state_e;

endpackage

// [verilog/swc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// three-stage pin synchroniser; output changes once stages two and three agree
module swc_sync
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage is read only by the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level <= s3_q;
    end
  end
endmodule // swc_sync
`default_nettype wire

// [tb/swc_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module swc_top_tb;
  import swc_pkg::*;
  logic        hclk            = 1'b0;
  logic        hresetn         = 1'b0;
  logic        hsel            = 1'b0;
  logic [7:0]  haddr           = 8'h00;
  logic [1:0]  htrans          = 2'h0;
  logic        hwrite          = 1'b0;
  logic [31:0] hwdata          = 32'h0000_0000;
  logic        ext_reset_pin_n = 1'b1;
  logic [8:0]  irq_flags       = 9'h000;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_enable;
  logic        core_halt;
  logic        prefetch_next;
  logic        vector_req;
  logic        device_reset;
  logic [15:0] vector_addr;
  logic [15:0] vec_seen;
  logic [31:0] rd;
  int          failures  = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  int          pf_cnt    = 0;
  int          vec_cnt   = 0;
  int          p0;
  int          n;

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  swc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_reset_pin_n(ext_reset_pin_n), .irq_flags(irq_flags), .osc_enable(osc_enable),
    .core_halt(core_halt), .prefetch_next(prefetch_next), .vector_req(vector_req),
    .vector_addr(vector_addr), .device_reset(device_reset));

  always #5 hclk = ~hclk;

  // pulse counters, and a guard so a stuck wait cannot hang the run
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (prefetch_next === 1'b1)
      pf_cnt <= pf_cnt + 1;
    if (vector_req === 1'b1)
    begin
      vec_cnt  <= vec_cnt + 1;
      vec_seen <= vector_addr;
    end
    if (cycles == 60000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one ahb-lite single transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1 && k < 50)
    begin
      @(posedge hclk);
      k++;
    end
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && k < 50)
    begin
      @(posedge hclk);
      k++;
    end
    rd = hrdata;
  endtask

  task automatic st(input logic [2:0] s, input logic pd, input logic to, input string m);
    xfer(1'b0, SWC_STAT_OFS, 32'h0000_0000);
    chk({27'h0, rd[6:4], rd[1:0]}, {27'h0, s, to, pd}, m);
  endtask

  // polling is bounded and checks nothing; a following st call, where there is one, judges the outcome
  task automatic wait_st(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    xfer(1'b0, SWC_STAT_OFS, 32'h0000_0000);
    while (rd[6:4] !== s && k < lim)
    begin
      xfer(1'b0, SWC_STAT_OFS, 32'h0000_0000);
      k++;
    end
  endtask

  task automatic resume_run();
    irq_flags <= 9'h000;
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0004);
    wait_st(SWC_RUN, 20);
  endtask

  task automatic summarize();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    st(SWC_RUN, 1'b1, 1'b1, "reset flags");
    chk(osc_enable, 32'h1, "osc on after reset");
    xfer(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0, "unmapped read");
    chk(hresp, 32'h0, "okay response");
    chk(hreadyout, 32'h1, "zero wait states");
    $display("test reset done");
    // enabled flag already pending turns sleep into a no-op
    xfer(1'b1, SWC_IRQ_OFS, 32'h0000_0001);
    irq_flags <= 9'h001;
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    st(SWC_RUN, 1'b1, 1'b1, "pending sleep is nop");
    irq_flags <= 9'h000;
    $display("test nop done");
    // timer without async mode, clocked peripheral, unenabled source: no wake
    xfer(1'b1, SWC_CTRL_OFS, 32'h0000_0000);
    xfer(1'b1, SWC_IRQ_OFS, 32'h0000_0104);
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0001);
    irq_flags <= 9'h100;
    repeat (10) @(posedge hclk);
    irq_flags <= 9'h106;
    repeat (10) @(posedge hclk);
    st(SWC_SLEEP, 1'b0, 1'b1, "no wake");
    xfer(1'b1, SWC_CTRL_OFS, 32'h0000_001C);
    wait_st(SWC_NEXT, 20);
    st(SWC_NEXT, 1'b0, 1'b1, "async timer wakes");
    resume_run();
    $display("test blocked sources done");
    // every allowed source wakes in line with global enable clear
    p0 = vec_cnt;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, SWC_IRQ_OFS, 32'h1 << i);
      n = pf_cnt;
      xfer(1'b1, SWC_CMD_OFS, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      st(SWC_SLEEP, 1'b0, 1'b1, "asleep");
      chk(pf_cnt - n, 32'h1, "prefetch pulse");
      chk({osc_enable, core_halt}, 32'h1, "osc off, halted");
      irq_flags <= 9'h001 << i;
      wait_st(SWC_NEXT, 20);
      st(SWC_NEXT, 1'b0, 1'b1, "source wakes");
      resume_run();
      st(SWC_RUN, 1'b0, 1'b1, "resumed");
    end
    chk(vec_cnt - p0, 32'h0, "no vector with global enable clear");
    $display("test sources done");
    // global enable set: instruction after sleep, dummy cycles, then vector
    xfer(1'b1, SWC_IRQ_OFS, 32'h0000_8008);
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0001);
    irq_flags <= 9'h008;
    wait_st(SWC_NEXT, 20);
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0004);
    wait_st(SWC_RUN, 20);
    repeat (4) @(posedge hclk);
    chk(vec_cnt - p0, 32'h1, "one vector");
    chk(vec_seen, 32'h4, "vector address");
    irq_flags <= 9'h000;
    $display("test vector done");
    // crystal mode holds the start-up delay
    xfer(1'b1, SWC_CTRL_OFS, 32'h0000_0002);
    xfer(1'b1, SWC_IRQ_OFS, 32'h0000_0001);
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0001);
    irq_flags <= 9'h001;
    wait_st(SWC_OST, 20);
    st(SWC_OST, 1'b0, 1'b1, "start-up begun");
    repeat (900) @(posedge hclk);
    st(SWC_OST, 1'b0, 1'b1, "start-up still running");
    wait_st(SWC_NEXT, 100);
    st(SWC_NEXT, 1'b0, 1'b1, "start-up over");
    resume_run();
    $display("test crystal done");
    // watchdog wakes from sleep, resets in run
    xfer(1'b1, SWC_CTRL_OFS, 32'h0000_0001);
    xfer(1'b1, SWC_IRQ_OFS, 32'h0000_0000);
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0002);
    xfer(1'b0, SWC_WDTCNT_OFS, 32'h0000_0000);
    chk(rd, 32'h1, "watchdog cleared");
    xfer(1'b1, SWC_CMD_OFS, 32'h0000_0001);
    wait_st(SWC_NEXT, 200);
    st(SWC_NEXT, 1'b0, 1'b0, "watchdog wake");
    resume_run();
    n = 0;
    while (device_reset !== 1'b1 && n < 400)
    begin
      @(posedge hclk);
      n++;
    end
    chk(device_reset, 32'h1, "run timeout resets");
    xfer(1'b1, SWC_CTRL_OFS, 32'h0000_0000);
    $display("test watchdog done");
    // reset pin gives a device reset
    ext_reset_pin_n <= 1'b0;
    n = 0;
    while (device_reset !== 1'b1 && n < 10)
    begin
      @(posedge hclk);
      n++;
    end
    chk(device_reset, 32'h1, "pin reset");
    ext_reset_pin_n <= 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    st(SWC_RUN, 1'b1, 1'b1, "power-up flags");
    $display("test reset pin done");
    summarize();
  end
endmodule // swc_top_tb
`default_nettype wire
